/* verilog/bmsl_pkg.sv */
`default_nettype none
package bmsl_pkg;
   // Boot space and internal destination
   localparam logic [23:0] EXT_BOOT_BASE = 24'h80_0000;
   localparam logic [19:0] INT_BOOT_BASE = 20'h4_0000;
   localparam int BOOT_WORDS = 256;
   localparam int WORD_BITS = 48;
   // EPROM read timing
   localparam int EPROM_WAIT_STATES = 7;
   localparam int EPROM_ACCESS_CYCLES = EPROM_WAIT_STATES + 1;
   // Unit widths per source
   localparam logic [4:0] EPROM_UNIT_BITS = 5'h08;
   localparam logic [4:0] HOST_NARROW_BITS = 5'h08;
   localparam logic [4:0] HOST_WIDE_BITS = 5'h10;
   localparam logic [4:0] LINK_UNIT_BITS = 5'h04;
   localparam logic [4:0] SPI_UNIT_BITS = 5'h08;
   // DMA channel and link buffer numbers
   localparam logic [3:0] EXT_PORT_DMA_CH = 4'ha;
   localparam logic [3:0] SPI_DMA_CH = 4'h8;
   localparam logic [3:0] LINK_BUFFER_NUM = 4'h4;
   localparam logic [3:0] NO_DMA_CH = 4'hf;

   typedef enum logic [2:0] {
      MODE_EPROM = 3'b000,
      MODE_HOST = 3'b001,
      MODE_LINK = 3'b010,
      MODE_SPI = 3'b011,
      MODE_NOBOOT = 3'b100
   } bmsl_mode_t;

   typedef enum logic [1:0] {
      ST_STRAP = 2'b00,
      ST_LOAD = 2'b01,
      ST_DONE = 2'b10,
      ST_NOBOOT = 2'b11
   } bmsl_state_t;

   typedef struct packed {
      logic eprom;
      logic link;
      logic bootMemSel;
   } bmsl_straps_t;

   typedef struct packed {
      logic valid;
      logic [19:0] addr;
      logic [47:0] data;
   } bmsl_memwr_t;
endpackage
`default_nettype wire

/* verilog/bmsl_loader.sv */
// Function
// - Boot mode decided at reset from the three strap pin levels.
// - Eprom select high, link select low: load from 8-bit EPROM.
// - Both selects low, memory select high: boot from host processor.
// - Host boot accepts 8-bit or 16-bit host data.
// - Link select high, eprom low, memory select high: link port boot.
// - Link boot takes 4-bit nibbles into link buffer 4.
// - Link high, others low: SPI boot via receive buffer, DMA channel 8.
// - All straps low: no loading, execute from external memory.
// - EPROM mode drives memory select pin as the EPROM chip select.
// - Only the current bus master drives memory select in EPROM boot.
// - Memory select pin is three-statable when an output in EPROM boot.
// - Host, link and SPI modes use memory select as input only.
// - Selected mode's DMA channel set up for 256 instruction words.
// - EPROM boot moves data with DMA channel 10.
// - Narrow boot units packed into 48-bit instruction words.
// - Fill 256 internal addresses first to last, then start execution.
// - Each EPROM read has seven wait states, eight cycles total.
// - EPROM address starts at boot space base, steps by one per access.
`default_nettype none
module bmsl_loader #(
   parameter logic [3:0] LINK_DMA_CH = bmsl_pkg::LINK_BUFFER_NUM
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Boot straps
   input wire logic epromBootSelect,
   input wire logic linkBootSelect,
   // Boot memory select pin
   input wire logic bootMemSelectNIn,
   output logic bootMemSelectNOut,
   output logic bootMemSelectNOe,
   // Multiprocessor bus ownership
   input wire logic busMaster,
   // EPROM external port
   output logic [23:0] extAddr,
   output logic extRdN,
   input wire logic [7:0] bootByteLane,
   // Host stream
   input wire logic hostValid,
   input wire logic hostWide,
   input wire logic [15:0] hostData,
   output logic hostReady,
   // Link buffer stream
   input wire logic linkValid,
   input wire logic [3:0] linkNibble,
   output logic linkReady,
   // Serial receive buffer stream
   input wire logic spiValid,
   input wire logic [7:0] serialReceiveBuffer,
   output logic spiReady,
   // Internal memory writes and status
   output var bmsl_pkg::bmsl_memwr_t memWr,
   output logic [2:0] bootMode,
   output logic [3:0] dmaChannel,
   output logic bootDone,
   output logic execExternal
);
   bmsl_pkg::bmsl_state_t stateQ, stateD;
   bmsl_pkg::bmsl_mode_t modeQ, modeD;
   bmsl_pkg::bmsl_straps_t straps;
   bmsl_pkg::bmsl_memwr_t memWrD;
   logic [3:0] chanQ, chanD;
   logic [47:0] accQ, accD;
   logic [5:0] bitCntQ, bitCntD;
   logic [8:0] wordCntQ, wordCntD;
   logic rdActiveQ, rdActiveD;
   logic rdGapQ, rdGapD;
   logic [2:0] rdCntQ, rdCntD;
   logic [23:0] addrQ, addrD;
   logic loading;
   logic unitValid;
   logic [15:0] unitData;
   logic [4:0] unitBits;
   logic [47:0] unitTop;
   logic [5:0] bitSum;
   logic rdLast;

   assign straps = '{epromBootSelect, linkBootSelect, bootMemSelectNIn};
   assign loading = stateQ == bmsl_pkg::ST_LOAD;
   assign rdLast = rdActiveQ && rdCntQ == 3'(bmsl_pkg::EPROM_ACCESS_CYCLES - 1);

   // Handshakes stay low outside the selected mode
   assign hostReady = loading && modeQ == bmsl_pkg::MODE_HOST;
   assign linkReady = loading && modeQ == bmsl_pkg::MODE_LINK;
   assign spiReady = loading && modeQ == bmsl_pkg::MODE_SPI;

   // Source unit select
   always_comb begin
      unitValid = 1'b0;
      unitData = 16'h0000;
      unitBits = bmsl_pkg::EPROM_UNIT_BITS;
      case (modeQ)
         bmsl_pkg::MODE_EPROM: begin
            unitValid = rdLast;
            unitData = {8'h00, bootByteLane};
         end
         bmsl_pkg::MODE_HOST: begin
            unitValid = hostValid && hostReady;
            unitData = hostWide ? hostData : {8'h00, hostData[7:0]};
            unitBits = hostWide ? bmsl_pkg::HOST_WIDE_BITS : bmsl_pkg::HOST_NARROW_BITS;
         end
         bmsl_pkg::MODE_LINK: begin
            unitValid = linkValid && linkReady;
            unitData = {12'h000, linkNibble};
            unitBits = bmsl_pkg::LINK_UNIT_BITS;
         end
         bmsl_pkg::MODE_SPI: begin
            unitValid = spiValid && spiReady;
            unitData = {8'h00, serialReceiveBuffer};
            unitBits = bmsl_pkg::SPI_UNIT_BITS;
         end
         default: begin
            unitValid = 1'b0;
         end
      endcase
   end

   // Mode, packing and sequencing
   always_comb begin
      stateD = stateQ;
      modeD = modeQ;
      chanD = chanQ;
      accD = accQ;
      bitCntD = bitCntQ;
      wordCntD = wordCntQ;
      memWrD = '0;
      unitTop = {unitData, 32'h0000_0000} << (bmsl_pkg::HOST_WIDE_BITS - unitBits);
      bitSum = bitCntQ + 6'(unitBits);
      case (stateQ)
         bmsl_pkg::ST_STRAP: begin
            stateD = bmsl_pkg::ST_LOAD;
            chanD = bmsl_pkg::EXT_PORT_DMA_CH;
            if (straps.eprom && !straps.link) begin
               modeD = bmsl_pkg::MODE_EPROM;
            end else if (!straps.eprom && !straps.link && straps.bootMemSel) begin
               modeD = bmsl_pkg::MODE_HOST;
            end else if (!straps.eprom && straps.link && straps.bootMemSel) begin
               modeD = bmsl_pkg::MODE_LINK;
               chanD = LINK_DMA_CH;
            end else if (!straps.eprom && straps.link) begin
               modeD = bmsl_pkg::MODE_SPI;
               chanD = bmsl_pkg::SPI_DMA_CH;
            end else begin
               // no-boot, also taken for both selects high
               modeD = bmsl_pkg::MODE_NOBOOT;
               chanD = bmsl_pkg::NO_DMA_CH;
               stateD = bmsl_pkg::ST_NOBOOT;
            end
         end
         bmsl_pkg::ST_LOAD: begin
            if (unitValid) begin
               accD = (accQ >> unitBits) | unitTop;
               bitCntD = bitSum;
               if (bitSum == 6'(bmsl_pkg::WORD_BITS)) begin
                  memWrD.valid = 1'b1;
                  memWrD.addr = bmsl_pkg::INT_BOOT_BASE + 20'(wordCntQ);
                  memWrD.data = accD;
                  bitCntD = 6'h00;
                  wordCntD = wordCntQ + 9'h001;
                  if (wordCntQ == 9'(bmsl_pkg::BOOT_WORDS - 1)) begin
                     stateD = bmsl_pkg::ST_DONE;
                  end
               end
            end
         end
         default: begin
            stateD = stateQ;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         stateQ <= bmsl_pkg::ST_STRAP;
         modeQ <= bmsl_pkg::MODE_NOBOOT;
         chanQ <= bmsl_pkg::NO_DMA_CH;
         accQ <= 48'h0000_0000_0000;
         bitCntQ <= 6'h00;
         wordCntQ <= 9'h000;
         memWr <= '0;
      end else begin
         stateQ <= stateD;
         modeQ <= modeD;
         chanQ <= chanD;
         accQ <= accD;
         bitCntQ <= bitCntD;
         wordCntQ <= wordCntD;
         memWr <= memWrD;
      end
   end

   // EPROM read engine; a gap cycle separates reads so each strobe edge is visible
   always_comb begin
      rdActiveD = rdActiveQ;
      rdGapD = 1'b0;
      rdCntD = rdCntQ;
      addrD = addrQ;
      if (rdActiveQ) begin
         rdCntD = rdCntQ + 3'h1;
         if (rdLast) begin
            rdActiveD = 1'b0;
            rdGapD = 1'b1;
            rdCntD = 3'h0;
            addrD = addrQ + 24'h00_0001;
         end
      end else if (loading && modeQ == bmsl_pkg::MODE_EPROM && busMaster && !rdGapQ) begin
         rdActiveD = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdActiveQ <= 1'b0;
         rdGapQ <= 1'b0;
         rdCntQ <= 3'h0;
         addrQ <= bmsl_pkg::EXT_BOOT_BASE;
      end else begin
         rdActiveQ <= rdActiveD;
         rdGapQ <= rdGapD;
         rdCntQ <= rdCntD;
         addrQ <= addrD;
      end
   end

   assign extAddr = addrQ;
   assign extRdN = !rdActiveQ;

   assign bootMemSelectNOut = 1'b0;
   assign bootMemSelectNOe = loading && modeQ == bmsl_pkg::MODE_EPROM && busMaster;

   assign bootMode = modeQ;
   assign dmaChannel = chanQ;
   assign bootDone = stateQ == bmsl_pkg::ST_DONE;
   assign execExternal = stateQ == bmsl_pkg::ST_NOBOOT;

   // Checks
   logic [8:0] wrCount;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wrCount <= 9'h000;
      end else if (memWr.valid) begin
         wrCount <= wrCount + 9'h001;
      end
   end

   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);

   chk_memsel_input_only: assert property (
      modeQ != bmsl_pkg::MODE_EPROM |-> !bootMemSelectNOe)
      else $error("Memory select driven outside EPROM boot");
   chk_memsel_master_only: assert property (
      bootMemSelectNOe |-> busMaster && !bootMemSelectNOut)
      else $error("Memory select driven by non-master");
   chk_memsel_released: assert property (
      modeQ == bmsl_pkg::MODE_EPROM && !busMaster |-> !bootMemSelectNOe)
      else $error("Memory select not three-stated");
   chk_rd_eight_cycles: assert property (
      $fell(extRdN) |-> (!extRdN) [*8] ##1 extRdN)
      else $error("EPROM read not eight cycles");
   chk_addr_step: assert property (
      $rose(extRdN) |-> extAddr == $past(extAddr) + 24'h00_0001)
      else $error("EPROM address did not step by one");
   chk_addr_first: assert property (
      $fell(extRdN) && wordCntQ == 9'h000 && bitCntQ == 6'h00
      |-> extAddr == bmsl_pkg::EXT_BOOT_BASE)
      else $error("EPROM boot did not start at base");
   chk_fill_order: assert property (
      memWr.valid |-> memWr.addr == bmsl_pkg::INT_BOOT_BASE + 20'(wrCount))
      else $error("Internal write address out of order");
   chk_word_total: assert property (
      $rose(bootDone) |-> memWr.valid && wrCount == 9'(bmsl_pkg::BOOT_WORDS - 1))
      else $error("Boot ended without 256 words");
   chk_mode_held: assert property (
      stateQ != bmsl_pkg::ST_STRAP |=> $stable(modeQ))
      else $error("Boot mode changed after capture");
   chk_noboot_idle: assert property (
      execExternal |-> !memWr.valid && extRdN && !hostReady)
      else $error("No-boot mode moved data");
   chk_link_nibbles: assert property (
      modeQ == bmsl_pkg::MODE_LINK && memWr.valid |-> $past(linkValid, 1))
      else $error("Link word written without nibble");
   chk_eprom_decode: assert property (
      resetn && stateQ == bmsl_pkg::ST_STRAP && epromBootSelect && !linkBootSelect
      |=> modeQ == bmsl_pkg::MODE_EPROM)
      else $error("EPROM straps did not select EPROM boot");
   chk_host_decode: assert property (
      resetn && stateQ == bmsl_pkg::ST_STRAP && !epromBootSelect && !linkBootSelect
      && bootMemSelectNIn |=> modeQ == bmsl_pkg::MODE_HOST)
      else $error("Host straps did not select host boot");
   chk_noboot_decode: assert property (
      resetn && stateQ == bmsl_pkg::ST_STRAP && !epromBootSelect && !linkBootSelect
      && !bootMemSelectNIn |=> execExternal)
      else $error("Low straps did not select no-boot");
   chk_eprom_channel: assert property (
      modeQ == bmsl_pkg::MODE_EPROM |-> dmaChannel == bmsl_pkg::EXT_PORT_DMA_CH)
      else $error("EPROM boot not on external port channel");
   chk_spi_channel: assert property (
      modeQ == bmsl_pkg::MODE_SPI |-> dmaChannel == bmsl_pkg::SPI_DMA_CH)
      else $error("SPI boot not on serial channel");
   chk_link_channel: assert property (
      modeQ == bmsl_pkg::MODE_LINK |-> dmaChannel == LINK_DMA_CH)
      else $error("Link boot not on link buffer channel");

   cov_eprom_done: cover property (
      modeQ == bmsl_pkg::MODE_EPROM && $rose(bootDone));
   cov_host_wide: cover property (
      hostReady && hostValid && hostWide ##1 memWr.valid);
   cov_link_done: cover property (
      modeQ == bmsl_pkg::MODE_LINK && $rose(bootDone));
   cov_noboot: cover property ($rose(execExternal));
   cov_spi_word: cover property (
      modeQ == bmsl_pkg::MODE_SPI && memWr.valid);
endmodule
`default_nettype wire

/* dv/bmsl_eprom_model.sv */
`default_nettype none
module bmsl_eprom_model (
   // Clock
   input wire logic clk,
   // Select, strobe and address
   input wire logic csN,
   input wire logic rdN,
   input wire logic [23:0] addr,
   // Byte lane
   output logic [7:0] lane
);
   timeunit 1ns;
   timeprecision 1ps;
   initial lane = 8'h00;
   // byte on lane
   // Unselected lane toggles so a stale byte can never pass as good
   always @(posedge clk) begin
      if (csN === 1'b0 && rdN === 1'b0) begin
         lane <= addr[7:0] ^ 8'h5a;
      end else begin
         lane <= ~lane;
      end
   end
endmodule
`default_nettype wire

/* dv/bmsl_loader_tb_top.sv */
`default_nettype none
module bmsl_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic eSel = 1'b0, lSel = 1'b0, bStrap = 1'b1, busMaster = 1'b1;
   logic hostValid = 1'b0, hostWide = 1'b0, linkValid = 1'b0, spiValid = 1'b0;
   logic [15:0] hostData = 16'h0000;
   logic [3:0] linkNibble = 4'h0;
   logic [7:0] spiByte = 8'h00;
   logic memSelNOut, memSelOe, memSelNPin;
   logic extRdN, hostReady, linkReady, spiReady, bootDone, execExt;
   logic [23:0] extAddr;
   logic [7:0] lane;
   logic [2:0] bootMode;
   logic [3:0] dmaCh;
   bmsl_pkg::bmsl_memwr_t memWr;
   logic [19:0] qa[$];
   logic [47:0] qd[$];
   int badCount = 0;
   int testsRun = 0;

   always #5 clk = ~clk;
   // Pin level: driven chip select, otherwise the board strap
   assign memSelNPin = memSelOe ? memSelNOut : bStrap;

   bmsl_loader i_bmsl_loader (.clk(clk), .resetn(resetn), .epromBootSelect(eSel),
      .linkBootSelect(lSel), .bootMemSelectNIn(memSelNPin), .bootMemSelectNOut(memSelNOut),
      .bootMemSelectNOe(memSelOe), .busMaster(busMaster), .extAddr(extAddr), .extRdN(extRdN),
      .bootByteLane(lane), .hostValid(hostValid), .hostWide(hostWide), .hostData(hostData),
      .hostReady(hostReady), .linkValid(linkValid), .linkNibble(linkNibble),
      .linkReady(linkReady), .spiValid(spiValid), .serialReceiveBuffer(spiByte),
      .spiReady(spiReady), .memWr(memWr), .bootMode(bootMode), .dmaChannel(dmaCh),
      .bootDone(bootDone), .execExternal(execExt));
   bmsl_eprom_model i_bmsl_eprom_model (.clk(clk), .csN(memSelNPin), .rdN(extRdN),
      .addr(extAddr), .lane(lane));

   always @(posedge clk) begin
      if (memWr.valid === 1'b1) begin
         qa.push_back(memWr.addr);
         qd.push_back(memWr.data);
      end
   end

   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic testDone();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic rst(input logic e, input logic l, input logic b);
      resetn <= 1'b0;
      eSel <= e;
      lSel <= l;
      bStrap <= b;
      qa.delete();
      qd.delete();
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   function automatic logic [15:0] uv(input int i);
      return 16'(i * 291) ^ 16'hc3a5;
   endfunction

   // Units go LSB first, so unit j of a word sits at bit j times width
   function automatic logic [47:0] expw(input int k, input logic wide, input int w);
      int bits;
      logic [47:0] r;
      bits = (k == 1) ? 4 : ((k == 0 && wide) ? 16 : 8);
      r = '0;
      for (int j = 0; j < 48 / bits; j++) begin
         r |= (48'(uv(w * (48 / bits) + j)) & ((48'h1 << bits) - 1)) << (j * bits);
      end
      return r;
   endfunction

   // Ready is a level for the whole load, so units go back to back
   task automatic stream(input int k, input int n);
      logic [15:0] u;
      for (int i = 0; i < n; i++) begin
         u = uv(i);
         hostValid <= (k == 0);
         linkValid <= (k == 1);
         spiValid <= (k == 2);
         hostData <= u;
         linkNibble <= u[3:0];
         spiByte <= u[7:0];
         @(posedge clk);
      end
      hostValid <= 1'b0;
      linkValid <= 1'b0;
      spiValid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic words(input int k, input logic wide, input int nw);
      chk("word count", 48'(nw), 48'(qa.size()));
      for (int w = 0; w < nw && w < qa.size(); w++) begin
         chk("word addr", 48'(20'h4_0000 + w), 48'(qa[w]));
         chk("word data", expw(k, wide, w), qd[w]);
      end
   endtask

   task automatic t_modes();
      logic [2:0] em [8] = '{3'h4, 3'h1, 3'h3, 3'h2, 3'h0, 3'h0, 3'h4, 3'h4};
      logic [3:0] ed [8] = '{4'hf, 4'ha, 4'h8, bmsl_pkg::LINK_BUFFER_NUM, 4'ha, 4'ha,
         4'hf, 4'hf};
      logic [2:0] er;
      for (int i = 0; i < 8; i++) begin
         rst(i[2], i[1], i[0]);
         chk("mode", 48'(em[i]), 48'(bootMode));
         chk("dma channel", 48'(ed[i]), 48'(dmaCh));
         chk("exec external", 48'(em[i] == 3'h4), 48'(execExt));
         er = {em[i] == 3'h1, em[i] == 3'h2, em[i] == 3'h3};
         chk("readies", 48'(er), 48'({hostReady, linkReady, spiReady}));
         if (em[i] != 3'h0) begin
            chk("select drive", 48'h0, 48'(memSelOe));
         end
         eSel <= ~eSel;
         lSel <= ~lSel;
         bStrap <= ~bStrap;
         repeat (3) @(posedge clk);
         chk("held mode", 48'(em[i]), 48'(bootMode));
      end
      $display("done modes");
   endtask

   task automatic t_streams();
      rst(1'b0, 1'b0, 1'b1);
      hostWide <= 1'b1;
      stream(0, 768);
      words(0, 1'b1, 256);
      chk("boot done", 48'h1, 48'(bootDone));
      chk("ready after", 48'h0, 48'(hostReady));
      rst(1'b0, 1'b0, 1'b1);
      hostWide <= 1'b0;
      stream(0, 6);
      words(0, 1'b0, 1);
      chk("not done", 48'h0, 48'(bootDone));
      rst(1'b0, 1'b1, 1'b1);
      stream(1, 24);
      words(1, 1'b0, 2);
      rst(1'b0, 1'b1, 1'b0);
      stream(2, 6);
      words(2, 1'b0, 1);
      $display("done streams");
   endtask

   task automatic t_eprom();
      int g;
      logic [47:0] e;
      busMaster <= 1'b0;
      rst(1'b1, 1'b0, 1'b1);
      chk("idle drive", 48'h0, 48'(memSelOe));
      chk("idle strobe", 48'h1, 48'(extRdN));
      busMaster <= 1'b1;
      g = 0;
      while (extRdN !== 1'b0 && g < 20) begin
         @(posedge clk);
         #1;
         g++;
      end
      chk("first addr", 48'h80_0000, 48'(extAddr));
      chk("select pin", 48'h0, 48'(memSelNPin));
      g = 0;
      while (extRdN === 1'b0 && g < 20) begin
         @(posedge clk);
         #1;
         g++;
      end
      chk("low cycles", 48'h8, 48'(g));
      chk("next addr", 48'h80_0001, 48'(extAddr));
      g = 0;
      while (qa.size() == 0 && g < 100) begin
         @(posedge clk);
         g++;
      end
      e = '0;
      for (int j = 0; j < 6; j++) begin
         e |= 48'(8'(j) ^ 8'h5a) << (8 * j);
      end
      chk("eprom word", e, qd.size() ? qd[0] : 48'h0);
      busMaster <= 1'b0;
      repeat (20) @(posedge clk);
      chk("released strobe", 48'h1, 48'(extRdN));
      chk("released drive", 48'h0, 48'(memSelOe));
      $display("done eprom");
   endtask

   initial begin
      #500000;
      badCount++;
      testDone();
   end

   initial begin
      t_modes();
      t_streams();
      t_eprom();
      testDone();
   end
endmodule
`default_nettype wire
